// [core/mpb_pkg.sv]
`default_nettype none
package mpb_pkg;
  localparam int unsigned REG_W        = 56;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned REG_BYTES    = 7;
  localparam int unsigned ADC_W        = 10;
  // Register selector codes on the register access port.
  localparam logic [2:0] SEL_READBACK  = 3'h0;
  localparam logic [2:0] SEL_MEASURE   = 3'h1;
  localparam logic [2:0] SEL_CONTROL   = 3'h3;
  // Byte index is three bits wide.
  localparam logic [2:0] LAST_BYTE     = 3'h6;
  // Field positions (low bit) of the 10-bit packed readings.
  localparam int unsigned F_HI         = 30;
  localparam int unsigned F_MH         = 20;
  localparam int unsigned F_ML         = 10;
  localparam int unsigned F_LO         = 0;
  localparam int unsigned TRACK_OK_BIT = 40;
  // Control register fields.
  localparam int unsigned C_OVR_EN     = 46;
  localparam int unsigned C_RSV_HI_LSB = 47;
  localparam int unsigned C_RSV45      = 45;
  localparam int unsigned C_RSV43_LSB  = 43;
  localparam int unsigned C_SCHEME_LSB = 40;
  localparam int unsigned C_IMAX_LSB   = 30;
  localparam int unsigned C_VMAX_LSB   = 20;
  localparam int unsigned C_TDOFF_LSB  = 17;
  localparam int unsigned C_TDON_LSB   = 14;
  localparam int unsigned C_DUTY_LSB   = 5;
  localparam int unsigned C_SRC_SEL    = 4;
  localparam int unsigned C_MANUAL     = 3;
  localparam int unsigned C_SOFT_RST   = 2;
  localparam int unsigned C_CLK_OE     = 1;
  localparam int unsigned C_OPEN_LOOP  = 0;
  localparam logic [55:0] CTRL_RESET   = 56'h00_08ff_fff6_dfe0;
  // Reserved bits 44:43 reset to 2'b01 and no reserved bit is writable.
  localparam logic [55:0] CTRL_WMASK   = 56'h00_47ff_ffff_ffff;
  localparam int unsigned TD_DIV       = 256;
  // Bypass drive square wave.
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BYP_HZ       = 440_000;
  localparam int unsigned BYP_HALF     = CLK_HZ / (2 * BYP_HZ);
  localparam logic [7:0]  BYP_HALF_M1  = 8'(BYP_HALF - 1);
endpackage : mpb_pkg
`default_nettype wire

// [core/mpb_sq_gen.sv]
`default_nettype none
module mpb_sq_gen
  import mpb_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      wave
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       wave;
  } mpb_sq_t;
  mpb_sq_t s_r, s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (!run)
    begin
      s_nxt = '0;
    end
    else if (s_r.cnt == BYP_HALF_M1)
    begin
      s_nxt.cnt  = 8'h00;
      s_nxt.wave = ~s_r.wave;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign wave = s_r.wave;

  AST_HALF_PERIOD: assert property (@(posedge mclk) disable iff (!rst_n)
    (run && s_r.cnt == BYP_HALF_M1 && $past(run)) |=> (wave != $past(wave)))
    else $error("Bypass wave failed to toggle at half period."); // [R2]
endmodule // mpb_sq_gen
`default_nettype wire

// [core/mpb_regbank.sv]
// Operation
// [R1] Request pin low forces panel bypass mode regardless of tracking.
// [R2] Bypass active (1:1 tracking or request) toggles drive output at 440 kHz.
// [R3] Reset pin low stops all drive outputs immediately.
// [R4] Readback register packs four 10-bit configuration conversions, reset zero.
// [R5] Measurement register packs four sensed values plus tracking-start bit 40.
// [R6] Override enable bit 46 selects override fields over conversions.
// [R7] Scheme override bits 42:40 replace top three bits of channel 2.
// [R8] Current ceiling override bits 39:30, reset 1023, replace channel 4.
// [R9] Voltage ceiling override bits 29:20, reset 1023, replace channel 0.
// [R10] Dead times are field over 256 of switching period; default 3.
// [R11] Open-loop duty field bits 13:5, reset 0xff.
// [R12] Source select bit 4 ignores request pin and uses control bit 3.
// [R13] With source select, bit 3 commands bypass entry and exit.
// [R14] Host sets bit 0, then pulses soft reset, to enter open loop.
// [R15] Open loop disables tracking and drives the commanded duty.
// [R16] Control bit 1 routes the internal PLL clock to its output pin.
// [R17] Soft reset silences outputs and sensing; release keeps configuration readings.
// [R18] Registers are 56 bits, seven bytes, least significant byte first.
// [R19] Reserved bits read their reset values and ignore writes.
`default_nettype none
module mpb_regbank
  import mpb_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             panel_bypass_request_pin,
  input  wire logic             pll_clk_in,
  input  wire logic             track_unity,
  input  wire logic             track_start,
  input  wire logic             cfg_sample,
  input  wire logic [ADC_W-1:0] slew_setting_reading,
  input  wire logic [ADC_W-1:0] current_ceiling_reading,
  input  wire logic [ADC_W-1:0] operating_scheme_reading,
  input  wire logic [ADC_W-1:0] voltage_ceiling_reading,
  input  wire logic [ADC_W-1:0] vout_reading,
  input  wire logic [ADC_W-1:0] iout_reading,
  input  wire logic [ADC_W-1:0] vin_reading,
  input  wire logic [ADC_W-1:0] iin_reading,
  input  wire logic             acc_start,
  input  wire logic             acc_wr,
  input  wire logic [2:0]       acc_sel,
  input  wire logic             byte_wr_stb,
  input  wire logic [7:0]       byte_wr_data,
  input  wire logic             byte_rd_stb,
  output logic      [7:0]       byte_rd_data,
  output logic                  sel_valid,
  output logic                  bypass_active,
  output logic                  bypass_drive_output,
  output logic                  pll_clk_out,
  output logic                  drive_enable,
  output logic                  sense_enable,
  output logic                  open_loop_active,
  output logic      [8:0]       fixed_duty_command,
  output logic      [2:0]       scheme_eff,
  output logic      [9:0]       scheme_reading_eff,
  output logic      [9:0]       current_ceiling_eff,
  output logic      [9:0]       voltage_ceiling_eff,
  output logic      [2:0]       rect_deadtime,
  output logic      [2:0]       main_deadtime
);
  typedef struct packed {
    logic              pin_s1;
    logic              pin_s2;
    logic [REG_W-1:0]  readback;
    logic [REG_W-1:0]  measure;
    logic [REG_W-1:0]  ctrl;
    logic [REG_W-1:0]  wr_shadow;
    logic [REG_W-1:0]  rd_shadow;
    logic [2:0]        sel;
    logic              wr;
    logic [2:0]        idx;
    logic              open_loop;
    logic              soft_q;
    logic [7:0]        rd_data;
  } mpb_regbank_t;
  mpb_regbank_t s_r, s_nxt;

  function automatic logic [REG_W-1:0] pack4(input logic [9:0] a, input logic [9:0] b,
                                             input logic [9:0] c, input logic [9:0] d);
    logic [REG_W-1:0] v;
    v = '0;
    v[F_HI +: ADC_W] = a;
    v[F_MH +: ADC_W] = b;
    v[F_ML +: ADC_W] = c;
    v[F_LO +: ADC_W] = d;
    return v;
  endfunction

  logic soft_rst;
  logic bypass_req;
  logic [REG_W-1:0] wr_merged;

  always_comb
  begin
    s_nxt        = s_r;
    soft_rst     = s_r.ctrl[C_SOFT_RST];
    s_nxt.pin_s1 = panel_bypass_request_pin;
    s_nxt.pin_s2 = s_r.pin_s1;
    wr_merged    = s_r.wr_shadow;
    // The index passes the last byte after a full block, so the merge is guarded to stay in range.
    if (s_r.idx <= LAST_BYTE)
    begin
      wr_merged[s_r.idx*BYTE_W +: BYTE_W] = byte_wr_data;
    end
    // Conversions are captured only on a configuration sampling event, never on soft-reset release.
    if (cfg_sample && !soft_rst)
    begin
      s_nxt.readback = pack4(slew_setting_reading, current_ceiling_reading,
                             operating_scheme_reading, voltage_ceiling_reading); // [R4] [R17]
    end
    if (!soft_rst && !s_r.open_loop)
    begin
      s_nxt.measure = pack4(vout_reading, iout_reading, vin_reading, iin_reading); // [R5] [R17] [R15]
      s_nxt.measure[TRACK_OK_BIT] = track_start; // [R5]
    end
    if (acc_start)
    begin
      s_nxt.sel = acc_sel;
      s_nxt.wr  = acc_wr;
      s_nxt.idx = 3'h0;
      s_nxt.wr_shadow = s_r.ctrl;
      unique case (acc_sel)
        SEL_READBACK: s_nxt.rd_shadow = s_r.readback;
        SEL_MEASURE:  s_nxt.rd_shadow = s_r.measure;
        SEL_CONTROL:  s_nxt.rd_shadow = s_r.ctrl;
        default:      s_nxt.rd_shadow = '0;
      endcase
    end
    else if (byte_wr_stb && s_r.wr && s_r.sel == SEL_CONTROL && s_r.idx <= LAST_BYTE)
    begin
      s_nxt.wr_shadow = wr_merged; // [R18]
      s_nxt.idx = s_r.idx + 3'h1;
      // The register only commits after all seven bytes, so a short write changes nothing.
      if (s_r.idx == LAST_BYTE)
      begin
        s_nxt.ctrl = (wr_merged & CTRL_WMASK) | (CTRL_RESET & ~CTRL_WMASK); // [R19] [R18]
      end
    end
    else if (byte_rd_stb && !s_r.wr && s_r.idx <= LAST_BYTE)
    begin
      s_nxt.rd_data = s_r.rd_shadow[s_r.idx*BYTE_W +: BYTE_W]; // [R18]
      s_nxt.idx = s_r.idx + 3'h1;
    end
    // Open loop is latched on soft-reset release so the host sequence governs entry.
    s_nxt.soft_q = soft_rst;
    if (s_r.soft_q && !soft_rst)
    begin
      s_nxt.open_loop = s_r.ctrl[C_OPEN_LOOP]; // [R14] [R15]
    end
    else if (!s_r.ctrl[C_OPEN_LOOP])
    begin
      s_nxt.open_loop = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r           <= '0;
      s_r.pin_s1    <= 1'b1;
      s_r.pin_s2    <= 1'b1;
      s_r.ctrl      <= CTRL_RESET; // [R10]
      s_r.wr_shadow <= CTRL_RESET;
    end
    else
      s_r <= s_nxt;
  end

  logic ovr;
  logic wave;
  assign ovr = s_r.ctrl[C_OVR_EN]; // [R6]
  assign bypass_req = s_r.ctrl[C_SRC_SEL] ? s_r.ctrl[C_MANUAL] : !s_r.pin_s2; // [R12] [R13] [R1]
  assign drive_enable = rst_n && !soft_rst; // [R3] [R17]
  assign sense_enable = drive_enable && !s_r.open_loop; // [R17] [R15]
  assign bypass_active = drive_enable && (bypass_req || (track_unity && !s_r.open_loop)); // [R1] [R2]

  mpb_sq_gen u_sq (
    .mclk  (mclk),
    .rst_n (rst_n),
    .run   (bypass_active),
    .wave  (wave)
  );

  // Gated by the reset pin directly so the drive stops without waiting for a clock edge.
  assign bypass_drive_output = wave && drive_enable; // [R3] [R2]
  assign pll_clk_out = pll_clk_in && s_r.ctrl[C_CLK_OE] && drive_enable; // [R16]
  assign open_loop_active = s_r.open_loop; // [R15]
  assign fixed_duty_command = s_r.ctrl[C_DUTY_LSB +: 9]; // [R11]
  assign scheme_eff = ovr ? s_r.ctrl[C_SCHEME_LSB +: 3] : s_r.readback[F_ML+7 +: 3]; // [R7]
  assign scheme_reading_eff = {scheme_eff, s_r.readback[F_ML +: 7]}; // [R7]
  assign current_ceiling_eff = ovr ? s_r.ctrl[C_IMAX_LSB +: ADC_W] : s_r.readback[F_MH +: ADC_W]; // [R8]
  assign voltage_ceiling_eff = ovr ? s_r.ctrl[C_VMAX_LSB +: ADC_W] : s_r.readback[F_LO +: ADC_W]; // [R9]
  // Dead time is field/TD_DIV of the switching period; the converter scales it.
  assign rect_deadtime = s_r.ctrl[C_TDON_LSB +: 3]; // [R10]
  assign main_deadtime = s_r.ctrl[C_TDOFF_LSB +: 3]; // [R10]
  assign byte_rd_data = s_r.rd_data;
  assign sel_valid = (s_r.sel == SEL_READBACK) || (s_r.sel == SEL_MEASURE) || (s_r.sel == SEL_CONTROL);

  AST_PIN_BYPASS: assert property (@(posedge mclk) disable iff (!rst_n)
    (!s_r.pin_s2 && !s_r.ctrl[C_SRC_SEL] && drive_enable) |-> bypass_active)
    else $error("Low request pin did not force bypass."); // [R1]
  AST_NO_WAVE_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
    (!bypass_active [*2]) |-> !bypass_drive_output)
    else $error("Bypass drive toggled outside bypass mode."); // [R2]
  AST_SOFT_SILENT: assert property (@(posedge mclk) disable iff (!rst_n)
    soft_rst |-> (!bypass_drive_output && !pll_clk_out && !sense_enable))
    else $error("Outputs active during soft reset."); // [R17]
  AST_OVR_IMAX: assert property (@(posedge mclk) disable iff (!rst_n)
    ovr |-> current_ceiling_eff == s_r.ctrl[C_IMAX_LSB +: ADC_W])
    else $error("Current ceiling override not applied."); // [R8]
  AST_OVR_VMAX: assert property (@(posedge mclk) disable iff (!rst_n)
    !ovr |-> voltage_ceiling_eff == s_r.readback[F_LO +: ADC_W])
    else $error("Voltage ceiling not taken from conversion."); // [R9]
  AST_MANUAL_SRC: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_r.ctrl[C_SRC_SEL] && !s_r.ctrl[C_MANUAL] && !track_unity) |-> !bypass_active)
    else $error("Request pin not ignored under manual source."); // [R12]
  AST_RSVD: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_r.ctrl & ~CTRL_WMASK) == (CTRL_RESET & ~CTRL_WMASK))
    else $error("Reserved control bits changed."); // [R19]
  AST_OPEN_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n)
    ($fell(soft_rst) && s_r.ctrl[C_OPEN_LOOP]) |=> open_loop_active)
    else $error("Open loop not entered on soft reset release."); // [R15]
  AST_RB_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cfg_sample) |=> $stable(s_r.readback))
    else $error("Readback changed without a sampling event."); // [R4]
endmodule // mpb_regbank
`default_nettype wire

// [tb/mpb_host_model.sv]
`default_nettype none
module mpb_host_model
  import mpb_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] byte_rd_data,
  output logic            acc_start,
  output logic            acc_wr,
  output logic [2:0]      acc_sel,
  output logic            byte_wr_stb,
  output logic [7:0]      byte_wr_data,
  output logic            byte_rd_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {acc_start, acc_wr, acc_sel, byte_wr_stb, byte_wr_data, byte_rd_stb} = '0;
  // Always whole seven-byte blocks, lowest byte first, strobes back to back.
  task automatic xfer(input logic [2:0] sel, input logic wr, input logic [55:0] wd, output logic [55:0] rd);
    @(negedge mclk);
    acc_start = 1'b1;
    acc_wr = wr;
    acc_sel = sel;
    for (int k = 0; k <= 7; k++)
    begin
      @(negedge mclk);
      acc_start = 1'b0;
      if (k > 0)
        rd[8*(k-1) +: 8] = byte_rd_data;
      byte_wr_stb = wr && k < 7;
      byte_rd_stb = !wr && k < 7;
      byte_wr_data = wd[8*(k%7) +: 8];
    end
  endtask
endmodule // mpb_host_model
`default_nettype wire

// [tb/mppt_config_register_bank_tb.sv]
`default_nettype none
module mppt_config_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mpb_pkg::*;
  logic mclk, rst_n, pin_n, pll, unity, tstart, csamp, ast, awr, wstb, rstb, selv;
  logic act, drv, pllo, den, sen, olp;
  logic [2:0] asel, sche, rdt, mdt, sch, tdf, tdn;
  logic [7:0] wdat, rdat;
  logic [9:0] cfg [4], live [4], sre, cce, vce, im, vm;
  logic [8:0] dc, duty;
  logic [55:0] r;
  logic [31:0] seed = 32'hbd41;
  int n, n_errors = 0, total_checks = 0;
  mpb_regbank dut_u (.mclk(mclk), .rst_n(rst_n), .panel_bypass_request_pin(pin_n), .pll_clk_in(pll),
    .track_unity(unity), .track_start(tstart), .cfg_sample(csamp), .slew_setting_reading(cfg[3]),
    .current_ceiling_reading(cfg[2]), .operating_scheme_reading(cfg[1]), .voltage_ceiling_reading(cfg[0]),
    .vout_reading(live[3]), .iout_reading(live[2]), .vin_reading(live[1]), .iin_reading(live[0]),
    .acc_start(ast), .acc_wr(awr), .acc_sel(asel), .byte_wr_stb(wstb), .byte_wr_data(wdat),
    .byte_rd_stb(rstb), .byte_rd_data(rdat), .sel_valid(selv), .bypass_active(act), .bypass_drive_output(drv),
    .pll_clk_out(pllo), .drive_enable(den), .sense_enable(sen), .open_loop_active(olp),
    .fixed_duty_command(duty), .scheme_eff(sche), .scheme_reading_eff(sre), .current_ceiling_eff(cce),
    .voltage_ceiling_eff(vce), .rect_deadtime(rdt), .main_deadtime(mdt));
  mpb_host_model host_u (.mclk(mclk), .byte_rd_data(rdat), .acc_start(ast), .acc_wr(awr), .acc_sel(asel),
    .byte_wr_stb(wstb), .byte_wr_data(wdat), .byte_rd_stb(rstb));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [55:0] ctl(input logic ovr, input logic [4:0] low);
    return {9'h0, ovr, 3'b001, sch, im, vm, tdf, tdn, dc, low};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [55:0] got, input logic [55:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // Bounded wait; running out of cycles ends the run as a failure.
  task automatic wait_lvl(ref logic s, input logic v);
    int i;
    for (i = 0; i < 400 && s !== v; i++)
      @(negedge mclk);
    if (i == 400)
    begin
      chk(s, v, "wait timeout");
      test_done();
    end
  endtask
  task automatic wctl(input logic ovr, input logic [4:0] low);
    logic [55:0] q;
    host_u.xfer(SEL_CONTROL, 1'b1, {9'(rnd()), ovr, 3'(rnd()), sch, im, vm, tdf, tdn, dc, low}, q);
    host_u.xfer(SEL_CONTROL, 1'b0, '0, q);
    chk(q, ctl(ovr, low), "control readback");
  endtask
  task automatic hard_reset();
    {sch, im, vm, tdf, tdn, dc} = {3'd0, 10'd1023, 10'd1023, 3'd3, 3'd3, 9'hff};
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    host_u.xfer(SEL_CONTROL, 1'b0, '0, r);
    chk(r, ctl(1'b0, 5'h0), "control reset");
  endtask
  initial
  begin
    {rst_n, pin_n, pll, unity, tstart, csamp} = 6'b010000;
    cfg = '{default: '0};
    live = '{default: '0};
    hard_reset();
    host_u.xfer(SEL_READBACK, 1'b0, '0, r);
    chk(r, '0, "readback reset");
    host_u.xfer(SEL_MEASURE, 1'b0, '0, r);
    chk(r, '0, "measure reset");
    host_u.xfer(3'h2, 1'b1, '1, r);
    host_u.xfer(3'h2, 1'b0, '0, r);
    chk(r, '0, "unmapped");
    chk(selv, 1'b0, "unmapped select");
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      foreach (cfg[k]) cfg[k] = 10'(rnd());
      foreach (live[k]) live[k] = 10'(rnd());
      tstart = 1'(rnd());
      csamp = 1'b1;
      @(negedge mclk);
      csamp = 1'b0;
      host_u.xfer(SEL_READBACK, 1'b1, 56'({rnd(), rnd()}), r);
      host_u.xfer(SEL_READBACK, 1'b0, '0, r);
      chk(r, {16'h0, cfg[3], cfg[2], cfg[1], cfg[0]}, "readback");
      host_u.xfer(SEL_MEASURE, 1'b0, '0, r);
      chk(r, {15'h0, tstart, live[3], live[2], live[1], live[0]}, "measure");
      chk({sche, cce, vce}, {cfg[1][9:7], cfg[2], cfg[0]}, "no override");
    end
    $display("test readings done");
    {sch, im, vm, tdf, tdn, dc} = 38'({rnd(), rnd()});
    wctl(1'b1, 5'b00010);
    chk({sche, sre, cce, vce}, {sch, sch, cfg[1][6:0], im, vm}, "override");
    chk({rdt, mdt, duty}, {tdn, tdf, dc}, "control fields");
    pll = 1'b1;
    #1 chk(pllo, 1'b1, "clock out");
    $display("test override done");
    pin_n = 1'b0;
    wait_lvl(act, 1'b1);
    wait_lvl(drv, 1'b0);
    wait_lvl(drv, 1'b1);
    for (n = 0; n < 300 && drv === 1'b1; n++)
      @(negedge mclk);
    chk(n, BYP_HALF, "half period");
    pin_n = 1'b1;
    wait_lvl(act, 1'b0);
    unity = 1'b1;
    wait_lvl(act, 1'b1);
    unity = 1'b0;
    wctl(1'b1, 5'b10000);
    pin_n = 1'b0;
    repeat (4) @(negedge mclk);
    chk(act, 1'b0, "pin ignored");
    wctl(1'b1, 5'b11000);
    chk(act, 1'b1, "manual bypass");
    wait_lvl(drv, 1'b1);
    pin_n = 1'b1;
    #2 rst_n = 1'b0;
    #1 chk({drv, pllo}, 2'b00, "hard reset stop");
    hard_reset();
    $display("test bypass done");
    dc = 9'(rnd());
    // Hard reset cleared the readback, so sample the configuration again before soft reset.
    csamp = 1'b1;
    @(negedge mclk);
    csamp = 1'b0;
    wctl(1'b0, 5'b00101);
    chk({den, sen, drv, pllo}, 4'b0000, "soft reset quiet");
    cfg[2] = ~cfg[2];
    csamp = 1'b1;
    @(negedge mclk);
    csamp = 1'b0;
    wctl(1'b0, 5'b00001);
    chk({olp, den, duty, cce}, {2'b11, dc, ~cfg[2]}, "open loop");
    $display("test open loop done");
    test_done();
  end
endmodule // mppt_config_register_bank_tb
`default_nettype wire
